// file: logic/ballast_pkg.sv
package ballast_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int DEAD_TIME_PS      = 1500000;
  localparam int DEAD_CYCLES       = (DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Default half period of the gate drive in run (about 45 kHz)
  localparam int RUN_HALF_CYCLES   = 1375;
  // Half period during preheat (about 68 kHz)
  localparam int PH_HALF_CYCLES    = 920;
  // Soft-start begins at this half period and rises by SOFT_STEP per low-side cycle
  localparam int SOFT_HALF_CYCLES  = 460;
  localparam int SOFT_STEP         = 4;
  // Ramp node model: 0 = grounded (preheat freq), max = run freq
  localparam int RAMP_W            = 10;
  localparam logic [9:0] RAMP_MAX  = 10'h3ff;
  localparam logic [9:0] RAMP_DIP  = 10'h010;

  // ------------------------------------------------------------
  // Event counting
  // ------------------------------------------------------------
  localparam int EVENT_LIMIT       = 60;
  localparam int EOL_LIMIT         = 60;
  localparam int CNT_W             = 7;
  localparam logic [6:0] CNT_RESET = 7'h00;

  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_LOCKOUT = 6'h01,
    ST_WARMUP  = 6'h02,
    ST_STRIKE  = 6'h04,
    ST_PRERUN  = 6'h08,
    ST_RUN     = 6'h10,
    ST_FAULT   = 6'h20
  } mode_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_on;        // Supply above turn-on level
    logic supply_off;       // Supply below off level
    logic hs_supply_on;     // Floating supply above its on level
    logic bus_above_5v;     // Bus monitor above enable level
    logic bus_below_3v;     // Bus monitor below disable level
    logic sd_above_5v;      // Shutdown input above 5 V
    logic sd_below_3v;      // Shutdown input below 3 V
    logic eol_window_bad;   // Shutdown input outside 1 V..3 V
    logic cph_above_2_3;    // Preheat node above two thirds
    logic cph_above_1_2;    // Preheat node above one half
    logic cph_below_1_3;    // Preheat node below one third
    logic cs_above_1v2;     // Current sense above 1.2 V
  } sense_t;

  // Switch and regulation controls toward the analog side
  typedef struct packed {
    logic osc_enable;       // Oscillator running
    logic cph_ground;       // Preheat node held to ground
    logic cph_discharge;    // Fast discharge of preheat node
    logic ramp_ground;      // Ramp node held to ground
    logic ramp_dip;         // Slight ramp discharge pulse
  } ctrl_t;

endpackage

// file: logic/gate_pair_driver.sv
`timescale 1ns/100ps
`default_nettype none
module gate_pair_driver #(
  parameter int DEAD = ballast_pkg::DEAD_CYCLES,
  parameter int HW   = 16
) (
  input  wire logic          mclk,       // System clock
  input  wire logic          reset_n,    // Synchronous reset
  input  wire logic          ce,         // Clock enable
  input  wire logic          run,        // Oscillate when high
  input  wire logic          hs_allow,   // High side may switch
  input  wire logic [HW-1:0] half_cyc,   // On-time per side
  output logic               lo_on,      // Low-side gate request
  output logic               ho_on,      // High-side gate request
  output logic               lo_cycle    // Pulse at low-side turn-off
);

  // ------------------------------------------------------------
  // Phase sequencer: low on, dead, high on, dead
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_LO   = 4'h1,
    PH_DLH  = 4'h2,
    PH_HO   = 4'h4,
    PH_DHL  = 4'h8
  } phase_t;

  phase_t        phase_ff, nxt_phase;
  logic [HW-1:0] cnt_ff, nxt_cnt;
  logic          lo_ff, nxt_lo, ho_ff, nxt_ho, cyc_ff, nxt_cyc;

  // Equal on-times give 50% duty; dead time between every edge
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff + 1'b1;
    nxt_cyc   = 1'b0;
    nxt_lo    = 1'b0;
    nxt_ho    = 1'b0;
    if (!run) begin
      nxt_phase = PH_DHL;
      nxt_cnt   = '0;
    end else begin
      case (phase_ff)
        PH_LO: begin
          nxt_lo = 1'b1;
          if (cnt_ff >= half_cyc - 1'b1) begin
            nxt_phase = PH_DLH;
            nxt_cnt   = '0;
            nxt_lo    = 1'b0;
            nxt_cyc   = 1'b1;
          end
        end
        PH_DLH: begin
          if (cnt_ff >= HW'(DEAD - 1)) begin
            nxt_phase = PH_HO;
            nxt_cnt   = '0;
            nxt_ho    = hs_allow;
          end
        end
        PH_HO: begin
          nxt_ho = hs_allow;
          if (cnt_ff >= half_cyc - 1'b1) begin
            nxt_phase = PH_DHL;
            nxt_cnt   = '0;
            nxt_ho    = 1'b0;
          end
        end
        default: begin
          if (cnt_ff >= HW'(DEAD - 1)) begin
            nxt_phase = PH_LO;
            nxt_cnt   = '0;
            nxt_lo    = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase_ff <= PH_DHL;
      cnt_ff   <= '0;
      lo_ff    <= 1'b0;
      ho_ff    <= 1'b0;
      cyc_ff   <= 1'b0;
    end else if (ce) begin
      phase_ff <= nxt_phase;
      cnt_ff   <= nxt_cnt;
      lo_ff    <= nxt_lo;
      ho_ff    <= nxt_ho;
      cyc_ff   <= nxt_cyc;
    end
  end

  assign lo_on    = lo_ff;
  assign ho_on    = ho_ff;
  assign lo_cycle = cyc_ff;

endmodule // gate_pair_driver
`default_nettype wire

// file: logic/ballast_mode_sequencer.sv
// Function
// - Supply below turn-on: gates low, oscillator stopped, preheat node grounded.
// - Start low side only with supply on, bus above 5 V, shutdown below 3 V.
// - High side switches only once its floating supply is up.
// - Alternate outputs at 50% duty with 1.5 us dead time.
// - Preheat: release preheat node, ground ramp, soft-start falling to preheat rate.
// - Stay in preheat until preheat node passes two thirds, then ignite.
// - Preheat keeps over-current detection and 60-cycle counter enabled.
// - First two-thirds crossing: discharge preheat node to one third, then release.
// - Ignition releases ramp ground so frequency sweeps down to run.
// - Ignition: sense above 1.2 V dips ramp node each cycle.
// - Ignition ends into pre-run when preheat node reaches one half.
// - Pre-run: a single over-current event causes fault.
// - Second two-thirds crossing enters run, counter back on, regulation off.
// - Run: over-current count above 60 faults and latches gates low.
// - Window check and bus undervoltage reset active only in run.
// - Counter counts up per over-current cycle, down per clean cycle.
// - Over-current is qualified by the low-side drive being on.
// - Fault grounds both nodes; exits only on supply off or shutdown above 5 V.
// - Window violation faults only after about 60 low-side cycles.
`timescale 1ns/100ps
`default_nettype none
module ballast_mode_sequencer #(
  parameter int EVENTS = ballast_pkg::EVENT_LIMIT,
  parameter int HW     = 16
) (
  input  wire logic               mclk,           // 125 MHz clock
  input  wire logic               reset_n,        // Synchronous reset
  input  wire logic               ce,             // Clock enable
  input  wire ballast_pkg::sense_t sense_raw,     // Comparator pins
  output ballast_pkg::ctrl_t      ctrl,           // Analog switch controls
  output logic                    low_side_drive, // Low-side gate
  output logic                    high_side_drive,// High-side gate
  output ballast_pkg::mode_t      mode,           // Present mode
  output logic [ballast_pkg::RAMP_W-1:0] frequency_ramp_node // Ramp level
);

  localparam int SW = $bits(ballast_pkg::sense_t);

  // ------------------------------------------------------------
  // Pin synchronisers: three stages, change when last two agree
  // ------------------------------------------------------------
  logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
  ballast_pkg::sense_t sn;

  always_comb begin
    nxt_flt = flt_ff;
    for (int i = 0; i < SW; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_flt[i] = s3_ff[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      flt_ff <= '0;
    end else if (ce) begin
      s1_ff  <= sense_raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  assign sn = ballast_pkg::sense_t'(flt_ff);

  // ------------------------------------------------------------
  // Gate pair
  // ------------------------------------------------------------
  logic          osc_run, lo_on, ho_on, lo_cycle;
  logic [HW-1:0] half_cyc;

  gate_pair_driver #(.DEAD(ballast_pkg::DEAD_CYCLES), .HW(HW)) u_gates (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .ce       (ce),
    .run      (osc_run),
    .hs_allow (sn.hs_supply_on),
    .half_cyc (half_cyc),
    .lo_on    (lo_on),
    .ho_on    (ho_on),
    .lo_cycle (lo_cycle)
  );

  // ------------------------------------------------------------
  // Mode machine, event counters, ramp and soft-start
  // ------------------------------------------------------------
  ballast_pkg::mode_t mode_ff, nxt_mode;
  logic [ballast_pkg::CNT_W-1:0] oc_cnt_ff, nxt_oc_cnt, eol_cnt_ff, nxt_eol_cnt;
  logic [ballast_pkg::RAMP_W-1:0] ramp_ff, nxt_ramp;
  logic [HW-1:0] soft_ff, nxt_soft;
  logic          oc_seen_ff, nxt_oc_seen;
  logic          dis_ff, nxt_dis;         // Preheat node fast discharge active
  logic          dip_ff, nxt_dip;
  logic          counting;
  logic [HW-1:0] ramp_half;

  // Over-current latched during low-side on-time of each cycle
  always_comb begin
    nxt_oc_seen = oc_seen_ff;
    if (lo_cycle) nxt_oc_seen = 1'b0;
    if (lo_on && sn.cs_above_1v2) nxt_oc_seen = 1'b1;
  end

  // Half period follows the ramp between preheat and run rates
  assign ramp_half = HW'(ballast_pkg::PH_HALF_CYCLES
                   + (((ballast_pkg::RUN_HALF_CYCLES - ballast_pkg::PH_HALF_CYCLES)
                       * int'(ramp_ff)) / int'(ballast_pkg::RAMP_MAX)));

  assign counting = (mode_ff == ballast_pkg::ST_WARMUP)
                 || (mode_ff == ballast_pkg::ST_RUN);

  always_comb begin
    nxt_mode    = mode_ff;
    nxt_oc_cnt  = oc_cnt_ff;
    nxt_eol_cnt = eol_cnt_ff;
    nxt_ramp    = ramp_ff;
    nxt_soft    = soft_ff;
    nxt_dis     = dis_ff;
    nxt_dip     = 1'b0;

    // Up/down counter clocked by low-side cycles, floor at zero
    if (lo_cycle && counting) begin
      if (oc_seen_ff || (lo_on && sn.cs_above_1v2))
        nxt_oc_cnt = oc_cnt_ff + 1'b1;
      else if (oc_cnt_ff != '0)
        nxt_oc_cnt = oc_cnt_ff - 1'b1;
    end

    case (mode_ff)
      ballast_pkg::ST_LOCKOUT: begin
        nxt_oc_cnt  = ballast_pkg::CNT_RESET;
        nxt_eol_cnt = ballast_pkg::CNT_RESET;
        nxt_ramp    = '0;
        nxt_dis     = 1'b0;
        nxt_soft    = HW'(ballast_pkg::SOFT_HALF_CYCLES);
        if (sn.supply_on && sn.bus_above_5v && sn.sd_below_3v)
          nxt_mode = ballast_pkg::ST_WARMUP;
      end
      ballast_pkg::ST_WARMUP: begin
        nxt_ramp = '0;
        // Soft-start half period stretches toward preheat rate
        if (lo_cycle && soft_ff < HW'(ballast_pkg::PH_HALF_CYCLES))
          nxt_soft = soft_ff + HW'(ballast_pkg::SOFT_STEP);
        if (sn.cph_above_2_3) begin
          nxt_mode = ballast_pkg::ST_STRIKE;
          nxt_dis  = 1'b1;
        end
        if (32'(oc_cnt_ff) >= EVENTS) nxt_mode = ballast_pkg::ST_FAULT;
      end
      ballast_pkg::ST_STRIKE: begin
        if (dis_ff && sn.cph_below_1_3) nxt_dis = 1'b0;
        // Dip on every over-current cycle; floor at zero rather than skip it
        if (lo_cycle && oc_seen_ff) begin
          nxt_ramp = ramp_ff - ballast_pkg::RAMP_DIP;
          if (ramp_ff <= ballast_pkg::RAMP_DIP) nxt_ramp = '0;
          nxt_dip  = 1'b1;
        end else if (lo_cycle && ramp_ff != ballast_pkg::RAMP_MAX)
          nxt_ramp = ramp_ff + 1'b1;
        if (!dis_ff && sn.cph_above_1_2)
          nxt_mode = ballast_pkg::ST_PRERUN;
      end
      ballast_pkg::ST_PRERUN: begin
        if (lo_cycle && ramp_ff != ballast_pkg::RAMP_MAX)
          nxt_ramp = ramp_ff + 1'b1;
        nxt_oc_cnt = ballast_pkg::CNT_RESET;
        if (lo_on && sn.cs_above_1v2)
          nxt_mode = ballast_pkg::ST_FAULT;
        else if (sn.cph_above_2_3)
          nxt_mode = ballast_pkg::ST_RUN;
      end
      ballast_pkg::ST_RUN: begin
        nxt_ramp = ballast_pkg::RAMP_MAX;
        if (lo_cycle) begin
          if (sn.eol_window_bad) nxt_eol_cnt = eol_cnt_ff + 1'b1;
          else nxt_eol_cnt = ballast_pkg::CNT_RESET;
        end
        if (32'(oc_cnt_ff) > EVENTS)
          nxt_mode = ballast_pkg::ST_FAULT;
        else if (32'(eol_cnt_ff) >= ballast_pkg::EOL_LIMIT)
          nxt_mode = ballast_pkg::ST_FAULT;
        else if (sn.bus_below_3v)
          nxt_mode = ballast_pkg::ST_LOCKOUT;
      end
      ballast_pkg::ST_FAULT: begin
        nxt_ramp = '0;
        nxt_dis  = 1'b0;
        if (sn.supply_off || sn.sd_above_5v)
          nxt_mode = ballast_pkg::ST_LOCKOUT;
      end
      default: nxt_mode = ballast_pkg::ST_LOCKOUT;
    endcase

    // Supply loss overrides every mode but fault, which waits for the off level
    if (!sn.supply_on && mode_ff != ballast_pkg::ST_FAULT)
      nxt_mode = ballast_pkg::ST_LOCKOUT;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_ff    <= ballast_pkg::ST_LOCKOUT;
      oc_cnt_ff  <= ballast_pkg::CNT_RESET;
      eol_cnt_ff <= ballast_pkg::CNT_RESET;
      ramp_ff    <= '0;
      soft_ff    <= HW'(ballast_pkg::SOFT_HALF_CYCLES);
      oc_seen_ff <= 1'b0;
      dis_ff     <= 1'b0;
      dip_ff     <= 1'b0;
    end else if (ce) begin
      mode_ff    <= nxt_mode;
      oc_cnt_ff  <= nxt_oc_cnt;
      eol_cnt_ff <= nxt_eol_cnt;
      ramp_ff    <= nxt_ramp;
      soft_ff    <= nxt_soft;
      oc_seen_ff <= nxt_oc_seen;
      dis_ff     <= nxt_dis;
      dip_ff     <= nxt_dip;
    end
  end

  // Oscillator only in the switching modes; fault latches gates low
  assign osc_run  = (mode_ff == ballast_pkg::ST_WARMUP) || (mode_ff == ballast_pkg::ST_STRIKE)
                 || (mode_ff == ballast_pkg::ST_PRERUN) || (mode_ff == ballast_pkg::ST_RUN);
  assign half_cyc = (mode_ff == ballast_pkg::ST_WARMUP) ? soft_ff : ramp_half;

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  ballast_pkg::ctrl_t ctrl_ff, nxt_ctrl;
  logic               lo_q_ff, ho_q_ff;

  always_comb begin
    nxt_ctrl.osc_enable    = (nxt_mode != ballast_pkg::ST_LOCKOUT)
                          && (nxt_mode != ballast_pkg::ST_FAULT);
    nxt_ctrl.cph_ground    = (nxt_mode == ballast_pkg::ST_LOCKOUT)
                          || (nxt_mode == ballast_pkg::ST_FAULT);
    nxt_ctrl.cph_discharge = nxt_dis;
    nxt_ctrl.ramp_ground   = (nxt_mode == ballast_pkg::ST_WARMUP)
                          || (nxt_mode == ballast_pkg::ST_LOCKOUT)
                          || (nxt_mode == ballast_pkg::ST_FAULT);
    nxt_ctrl.ramp_dip      = nxt_dip && (nxt_mode == ballast_pkg::ST_STRIKE);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_ff <= '{osc_enable: 1'b0, cph_ground: 1'b1, cph_discharge: 1'b0,
                   ramp_ground: 1'b1, ramp_dip: 1'b0};
      lo_q_ff <= 1'b0;
      ho_q_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      lo_q_ff <= lo_on && osc_run;
      ho_q_ff <= ho_on && osc_run && !lo_on;
    end
  end

  assign ctrl                = ctrl_ff;
  assign low_side_drive      = lo_q_ff;
  assign high_side_drive     = ho_q_ff;
  assign mode                = mode_ff;
  assign frequency_ramp_node = ramp_ff;

endmodule // ballast_mode_sequencer
`default_nettype wire

// file: bench/ballast_mode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ballast_mode_monitor #(
  parameter int EVENTS = ballast_pkg::EVENT_LIMIT,
  parameter int HW     = 16
) (
  input wire logic                               mclk,            // Clock
  input wire logic                               reset_n,         // Sync reset
  input wire logic                               ce,              // Clock enable
  input wire ballast_pkg::sense_t                sense_raw,       // Comparators
  input wire ballast_pkg::ctrl_t                 ctrl,            // Switch controls
  input wire logic                               low_side_drive,  // Low gate
  input wire logic                               high_side_drive, // High gate
  input wire ballast_pkg::mode_t                 mode,            // Mode
  input wire logic [ballast_pkg::RAMP_W-1:0]     frequency_ramp_node // Ramp
);
  localparam int DEAD = ballast_pkg::DEAD_CYCLES;
  logic [8:0] gap_ff;
  logic [8:0] nxt_gap;
  logic       hs_seen_ff;
  logic       nxt_hs_seen;

  // ----------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------
  // Both-low run length, saturating so lockout idle never wraps
  always_comb begin
    nxt_gap     = (low_side_drive || high_side_drive) ? 9'h000 :
                  ((gap_ff == 9'h1ff) ? gap_ff : gap_ff + 9'h001);
    nxt_hs_seen = (mode == ballast_pkg::ST_LOCKOUT) ? 1'h0 :
                  (hs_seen_ff || sense_raw.hs_supply_on);
  end
  always_ff @(posedge mclk) begin
    gap_ff     <= reset_n ? nxt_gap : 9'h000;
    hs_seen_ff <= reset_n ? nxt_hs_seen : 1'h0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_lockout_quiet: assert property (
    (mode == ballast_pkg::ST_LOCKOUT) && ($past(mode, 2) == ballast_pkg::ST_LOCKOUT)
    |-> !low_side_drive && !high_side_drive && !ctrl.osc_enable && ctrl.cph_ground)
    else $error("lockout outputs not quiet");
  chk_start_cond: assert property (
    $changed(mode) && (mode == ballast_pkg::ST_WARMUP) |-> $past(sense_raw.supply_on, 2)
    && $past(sense_raw.bus_above_5v, 2) && $past(sense_raw.sd_below_3v, 2))
    else $error("warmup entered without start conditions");
  chk_hs_supply: assert property ($rose(high_side_drive) |-> hs_seen_ff)
    else $error("high side switched before its supply");
  chk_no_overlap: assert property (!(low_side_drive && high_side_drive))
    else $error("gate outputs overlap");
  chk_dead_gap: assert property (
    $rose(low_side_drive) || $rose(high_side_drive) |-> gap_ff >= DEAD - 1)
    else $error("dead time too short");
  chk_warmup_ctrl: assert property (
    $changed(mode) && (mode == ballast_pkg::ST_WARMUP)
    |-> ctrl.osc_enable && !ctrl.cph_ground && ctrl.ramp_ground)
    else $error("warmup controls wrong");
  chk_strike_ctrl: assert property (
    $changed(mode) && (mode == ballast_pkg::ST_STRIKE)
    |-> $past(mode) == ballast_pkg::ST_WARMUP && ctrl.cph_discharge && !ctrl.ramp_ground)
    else $error("strike entry wrong");
  chk_dip_strike: assert property (ctrl.ramp_dip |-> mode == ballast_pkg::ST_STRIKE)
    else $error("ramp dip outside strike");
  chk_run_order: assert property (
    $changed(mode) && (mode inside {ballast_pkg::ST_PRERUN, ballast_pkg::ST_RUN})
    |-> $past(mode) == ((mode == ballast_pkg::ST_RUN) ? ballast_pkg::ST_PRERUN
                                                     : ballast_pkg::ST_STRIKE))
    else $error("mode order broken");
  chk_fault_latch: assert property (
    (mode == ballast_pkg::ST_FAULT) && ($past(mode, 2) == ballast_pkg::ST_FAULT)
    |-> !low_side_drive && !high_side_drive && ctrl.cph_ground && ctrl.ramp_ground)
    else $error("fault outputs not latched");
  chk_fault_exit: assert property (
    ($past(mode) == ballast_pkg::ST_FAULT) && (mode != ballast_pkg::ST_FAULT)
    |-> mode == ballast_pkg::ST_LOCKOUT)
    else $error("fault left to wrong mode");

  cov_run: cover property ($changed(mode) && mode == ballast_pkg::ST_RUN);
  cov_fault: cover property ($changed(mode) && mode == ballast_pkg::ST_FAULT);
  cov_hs: cover property ($rose(high_side_drive));
endmodule // ballast_mode_monitor
`default_nettype wire

// file: bench/bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_model (
  input  wire logic               mclk,           // Clock
  input  wire ballast_pkg::ctrl_t ctrl,           // Switch controls
  input  wire logic               low_side_drive, // Low gate
  input  wire logic               freeze,         // Stop node charging
  input  wire logic               oc_inject,      // Force over-current
  output logic                    hs_on,          // Floating supply up
  output logic                    a23,            // Node above 2/3
  output logic                    a12,            // Node above 1/2
  output logic                    b13,            // Node below 1/3
  output logic                    cs_hi           // Sense above 1.2 V
);
  int   preheat_timing_node  = 0;
  int   lo_n = 0;
  logic lo_d = 1'h0;

  // ----------------------------------------------------------
  // Node and bootstrap model
  // ----------------------------------------------------------
  // Bootstrap needs three low-side pulses, so the high side lags
  always @(posedge mclk) begin
    lo_d <= low_side_drive;
    if (!ctrl.osc_enable) lo_n <= 0;
    else if (low_side_drive && !lo_d && lo_n < 3) lo_n <= lo_n + 1;
    if (ctrl.cph_ground) preheat_timing_node <= 0;
    else if (ctrl.cph_discharge) preheat_timing_node <= (preheat_timing_node > 4) ? preheat_timing_node - 4 : 0;
    else if (!freeze && preheat_timing_node < 300) preheat_timing_node <= preheat_timing_node + 1;
  end
  // Steady sense level: counts only through the design's low-side gating
  assign hs_on = (lo_n >= 3);
  assign a23   = (preheat_timing_node > 200);
  assign a12   = (preheat_timing_node > 150);
  assign b13   = (preheat_timing_node < 100);
  assign cs_hi = oc_inject;
endmodule // bridge_model
`default_nettype wire

// file: bench/ballast_mode_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ballast_mode_sequencer_tb;
  localparam int EVENTS = 3;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic sup_on = 1'h0, sup_off = 1'h1, bus_hi = 1'h0, bus_lo = 1'h1;
  logic sd_hi = 1'h0, sd_lo = 1'h1, freeze = 1'h0, oc = 1'h0;
  logic hs_on, a23, a12, b13, cs_hi, low_side_drive, high_side_drive;
  ballast_pkg::sense_t sense_raw;
  ballast_pkg::ctrl_t  ctrl;
  ballast_pkg::mode_t  mode;
  logic [ballast_pkg::RAMP_W-1:0] ramp_node;
  int n_errors = 0;
  int checks_done = 0;

  // ----------------------------------------------------------
  // Clock, harness and partner
  // ----------------------------------------------------------
  always #4 mclk = ~mclk;
  assign sense_raw = {sup_on, sup_off, hs_on, bus_hi, bus_lo, sd_hi, sd_lo, 1'h0,
                      a23, a12, b13, cs_hi};
  ballast_mode_sequencer #(.EVENTS(EVENTS), .HW(16)) u_ballast_mode_sequencer (
    .mclk(mclk), .reset_n(reset_n), .ce(1'h1), .sense_raw(sense_raw), .ctrl(ctrl),
    .low_side_drive(low_side_drive), .high_side_drive(high_side_drive), .mode(mode),
    .frequency_ramp_node(ramp_node));
  bridge_model u_bridge_model (
    .mclk(mclk), .ctrl(ctrl), .low_side_drive(low_side_drive), .freeze(freeze),
    .oc_inject(oc), .hs_on(hs_on), .a23(a23), .a12(a12), .b13(b13), .cs_hi(cs_hi));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cmp_mode(input string nm, input ballast_pkg::mode_t exp);
    checks_done++;
    if (mode !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, mode);
    end
  endtask
  // Bounded wait; a timeout shows up as a mode mismatch
  task automatic wait_mode(input ballast_pkg::mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge mclk);
    cmp_mode("mode", m);
  endtask
  // Watched level: 0 low gate, 1 ramp dip, 2 high gate
  function automatic logic sig_of(input int which);
    return (which == 2) ? high_side_drive : (which == 1) ? ctrl.ramp_dip : low_side_drive;
  endfunction
  task automatic wait_sig(input int which, input logic lvl, input int lim);
    for (int i = 0; i < lim && sig_of(which) !== lvl; i++) @(negedge mclk);
    cmp_bit((which == 2) ? "high_side_drive" : which ? "ramp_dip" : "low_side_drive", lvl,
            sig_of(which));
  endtask
  task automatic lo_fall();
    wait_sig(0, 1'h1, 8000);
    wait_sig(0, 1'h0, 8000);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_lockout();
    repeat (10) @(negedge mclk);
    cmp_mode("idle", ballast_pkg::ST_LOCKOUT);
    cmp_bit("lo", 1'h0, low_side_drive);
    cmp_bit("osc", 1'h0, ctrl.osc_enable);
    cmp_bit("cph_gnd", 1'h1, ctrl.cph_ground);
    sup_on = 1'h1; sup_off = 1'h0; bus_hi = 1'h1; bus_lo = 1'h0; sd_lo = 1'h0;
    repeat (20) @(negedge mclk);
    cmp_mode("sd_mid", ballast_pkg::ST_LOCKOUT);
    sd_lo = 1'h1;
    wait_mode(ballast_pkg::ST_WARMUP, 20);
    cmp_bit("cph_gnd", 1'h0, ctrl.cph_ground);
    cmp_bit("ramp_gnd", 1'h1, ctrl.ramp_ground);
    $display("test lockout done");
  endtask
  task automatic t_climb();
    wait_mode(ballast_pkg::ST_STRIKE, 3000);
    cmp_bit("ramp_gnd", 1'h0, ctrl.ramp_ground);
    cmp_bit("discharge", 1'h1, ctrl.cph_discharge);
    freeze = 1'h1; oc = 1'h1;
    wait_sig(1, 1'h1, 8000);
    cmp_mode("dip_mode", ballast_pkg::ST_STRIKE);
    freeze = 1'h0; oc = 1'h0;
    wait_mode(ballast_pkg::ST_PRERUN, 3000);
    wait_mode(ballast_pkg::ST_RUN, 3000);
    wait_sig(2, 1'h1, 8000);
    $display("test climb done");
  endtask
  task automatic t_run_fault();
    lo_fall();
    cmp_bit("ramp_max", 1'h1, ramp_node == ballast_pkg::RAMP_MAX);
    oc = 1'h1;
    repeat (EVENTS) lo_fall();
    repeat (10) @(negedge mclk);
    cmp_mode("at_limit", ballast_pkg::ST_RUN);
    lo_fall();
    repeat (10) @(negedge mclk);
    cmp_mode("over_limit", ballast_pkg::ST_FAULT);
    cmp_bit("ramp_gnd", 1'h1, ctrl.ramp_ground);
    cmp_bit("cph_gnd", 1'h1, ctrl.cph_ground);
    oc = 1'h0;
    repeat (50) @(negedge mclk);
    cmp_mode("latched", ballast_pkg::ST_FAULT);
    sd_hi = 1'h1; sd_lo = 1'h0;
    wait_mode(ballast_pkg::ST_LOCKOUT, 20);
    sd_hi = 1'h0; sd_lo = 1'h1;
    wait_mode(ballast_pkg::ST_WARMUP, 20);
    $display("test run fault done");
  endtask
  task automatic t_prerun_fault();
    wait_mode(ballast_pkg::ST_STRIKE, 3000);
    wait_mode(ballast_pkg::ST_PRERUN, 3000);
    freeze = 1'h1; oc = 1'h1;
    wait_mode(ballast_pkg::ST_FAULT, 8000);
    repeat (3) @(negedge mclk);
    cmp_bit("lo", 1'h0, low_side_drive);
    freeze = 1'h0; oc = 1'h0; sup_on = 1'h0; sup_off = 1'h1;
    wait_mode(ballast_pkg::ST_LOCKOUT, 20);
    $display("test prerun fault done");
  endtask

  // Watchdog sized well above the roughly 23k cycles the tests need
  initial begin
    #(80000 * 8);
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    repeat (12) @(negedge mclk);
    reset_n = 1'h1;
    t_lockout();
    t_climb();
    t_run_fault();
    t_prerun_fault();
    wrap_up();
  end
endmodule // ballast_mode_sequencer_tb

bind ballast_mode_sequencer ballast_mode_monitor #(.EVENTS(EVENTS), .HW(HW))
  u_ballast_mode_monitor (.mclk(mclk), .reset_n(reset_n), .ce(ce), .sense_raw(sense_raw),
  .ctrl(ctrl), .low_side_drive(low_side_drive), .high_side_drive(high_side_drive),
  .mode(mode), .frequency_ramp_node(frequency_ramp_node));
`default_nettype wire
